/* include/hppsc_pkg.sv */
// shared constants for the hub port power and speed control block
package hppsc_pkg;
    // -------------------------------------------------------------
    // clocking
    // -------------------------------------------------------------
    localparam int unsigned HPPSC_CLK_HZ = 50_000_000;
    localparam int unsigned HPPSC_REF_HZ = 24_000_000;

    // -------------------------------------------------------------
    // geometry
    // -------------------------------------------------------------
    localparam int HPPSC_NPORTS = 2;
    localparam int HPPSC_AW = 8;

    // -------------------------------------------------------------
    // register byte offsets
    // -------------------------------------------------------------
    localparam logic [7:0] HPPSC_CTRL_OFS = 8'h00;
    localparam logic [7:0] HPPSC_PWRREQ_OFS = 8'h04;
    localparam logic [7:0] HPPSC_STATE_OFS = 8'h08;
    localparam logic [7:0] HPPSC_ISTAT_OFS = 8'h0c;
    localparam logic [7:0] HPPSC_ICLR_OFS = 8'h10;
    localparam logic [7:0] HPPSC_IEN_OFS = 8'h14;

    // -------------------------------------------------------------
    // control fields
    // -------------------------------------------------------------
    localparam int HPPSC_CTRL_GANG_BIT = 0;
    localparam int HPPSC_CTRL_CHG_LSB = 1;
    localparam int HPPSC_CTRL_CHG_W = 2;

    // -------------------------------------------------------------
    // state register fields
    // -------------------------------------------------------------
    localparam int HPPSC_ST_PWR_LSB = 0;
    localparam int HPPSC_ST_TRIP_LSB = 2;
    localparam int HPPSC_ST_SS_BIT = 4;
    localparam int HPPSC_ST_HS_BIT = 5;
    localparam int HPPSC_ST_CONN_BIT = 6;
    localparam int HPPSC_ST_CHG_LSB = 8;

    // -------------------------------------------------------------
    // interrupt status fields: one overcurrent bit per port, then
    // upstream connect change
    // -------------------------------------------------------------
    localparam int HPPSC_IRQ_W = 3;
    localparam int HPPSC_IRQ_CONN_BIT = 2;

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [2:0] HPPSC_CTRL_RST = 3'h0;
    localparam logic [1:0] HPPSC_PWRREQ_RST = 2'h0;
    localparam logic [2:0] HPPSC_IEN_RST = 3'h0;

    // -------------------------------------------------------------
    // bus encodings
    // -------------------------------------------------------------
    localparam logic [1:0] HPPSC_HTRANS_NONSEQ = 2'h2;
    localparam logic HPPSC_HRESP_OKAY = 1'b0;

    // charging behaviour while upstream is unconnected
    typedef enum logic [1:0] {
        HPPSC_CHG_OFF = 2'h0,
        HPPSC_CHG_DEDICATED = 2'h1,
        HPPSC_CHG_AUTO = 2'h2
    } hppsc_chg_t;
endpackage : hppsc_pkg

/* hw/hppsc_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module hppsc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // the first stage feeds only the second stage
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : hppsc_sync

/* hw/hppsc_top.sv */
// hub downstream port power, speed gating and charging mode control
`timescale 1ns/100ps
module hppsc_top
    import hppsc_pkg::*;
#(
    parameter int NPORTS = HPPSC_NPORTS
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic UP_SS_LINK,
    input wire logic UP_HS_LINK,
    input wire logic UP_CONNECTED,
    input wire logic [1:0] OVERCUR_N,
    output logic UP_SS_EN,
    output logic UP_HS_EN,
    output logic [1:0] DN_SS_EN,
    output logic [1:0] DN_HS_EN,
    output logic [1:0] PORT_PWR_EN,
    output logic CHARGING_DOWNSTREAM_HANDSHAKE,
    output logic DEDICATED_CHARGE_MODE,
    output logic AUTO_CHARGE_MODE,
    output logic IRQ
);
    // -------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------
    logic [4:0] pins_async;
    logic [4:0] pins_sync;
    logic up_ss_q;
    logic up_hs_q;
    logic up_conn_q;
    logic [1:0] oc_q;

    assign pins_async = {~OVERCUR_N, UP_CONNECTED, UP_HS_LINK, UP_SS_LINK};

    hppsc_sync #(
        .WIDTH(5)
    ) u_sync (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .async_in(pins_async),
        .sync_out(pins_sync)
    );

    assign up_ss_q = pins_sync[0];
    assign up_hs_q = pins_sync[1];
    assign up_conn_q = pins_sync[2];
    assign oc_q = pins_sync[4:3];

    // -------------------------------------------------------------
    // bus slave, zero wait states
    // -------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = (addr == ofs);
    endfunction : reg_hit

    logic [2:0] ctrl_reg;
    logic [1:0] pwr_req_reg;
    logic [2:0] int_en_reg;
    logic [2:0] int_stat_reg;
    logic [1:0] trip_reg;
    logic conn_prev_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic addr_ok;
    logic wr_ctrl;
    logic wr_req;
    logic wr_clr;
    logic wr_en;
    logic [31:0] state_word;
    logic [31:0] rd_next;
    logic gang_q;
    logic [1:0] chg_sel;

    assign HREADYOUT = 1'b1;
    assign HRESP = HPPSC_HRESP_OKAY;
    assign addr_ok = HSEL && HREADY && (HTRANS == HPPSC_HTRANS_NONSEQ);
    assign gang_q = ctrl_reg[HPPSC_CTRL_GANG_BIT];
    assign chg_sel = ctrl_reg[HPPSC_CTRL_CHG_LSB +: HPPSC_CTRL_CHG_W];

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && HWRITE;
            wr_addr_reg <= HADDR[7:0];
        end
    end

    // writes land in the data phase, using the latched address
    assign wr_ctrl = wr_pend_reg && reg_hit(wr_addr_reg, HPPSC_CTRL_OFS);
    assign wr_req = wr_pend_reg && reg_hit(wr_addr_reg, HPPSC_PWRREQ_OFS);
    assign wr_clr = wr_pend_reg && reg_hit(wr_addr_reg, HPPSC_ICLR_OFS);
    assign wr_en = wr_pend_reg && reg_hit(wr_addr_reg, HPPSC_IEN_OFS);

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ctrl_reg <= HPPSC_CTRL_RST;
            pwr_req_reg <= HPPSC_PWRREQ_RST;
            int_en_reg <= HPPSC_IEN_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= HWDATA[2:0];
            end
            if (wr_req) begin
                pwr_req_reg <= HWDATA[1:0];
            end
            if (wr_en) begin
                int_en_reg <= HWDATA[2:0];
            end
        end
    end

    // read data are registered at the address phase, ready in the data phase
    always_comb begin
        state_word = 32'h0000_0000;
        state_word[HPPSC_ST_PWR_LSB +: 2] = PORT_PWR_EN;
        state_word[HPPSC_ST_TRIP_LSB +: 2] = trip_reg;
        state_word[HPPSC_ST_SS_BIT] = up_ss_q;
        state_word[HPPSC_ST_HS_BIT] = up_hs_q;
        state_word[HPPSC_ST_CONN_BIT] = up_conn_q;
        state_word[HPPSC_ST_CHG_LSB +: 3] =
            {AUTO_CHARGE_MODE, DEDICATED_CHARGE_MODE, CHARGING_DOWNSTREAM_HANDSHAKE};
        rd_next = 32'h0000_0000;
        if (reg_hit(HADDR[7:0], HPPSC_CTRL_OFS)) begin
            rd_next = {29'h0, ctrl_reg};
        end else if (reg_hit(HADDR[7:0], HPPSC_PWRREQ_OFS)) begin
            rd_next = {30'h0, pwr_req_reg};
        end else if (reg_hit(HADDR[7:0], HPPSC_STATE_OFS)) begin
            rd_next = state_word;
        end else if (reg_hit(HADDR[7:0], HPPSC_ISTAT_OFS)) begin
            rd_next = {29'h0, int_stat_reg};
        end else if (reg_hit(HADDR[7:0], HPPSC_IEN_OFS)) begin
            rd_next = {29'h0, int_en_reg};
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_ok && !HWRITE) begin
            HRDATA <= rd_next;
        end
    end

    // -------------------------------------------------------------
    // overcurrent trip latches
    // -------------------------------------------------------------
    logic any_oc;
    logic [1:0] trip_set;
    logic [1:0] trip_ev;

    assign any_oc = |oc_q;

    // a trip holds the port off until software clears its status bit;
    // a still-present overcurrent re-trips, so the set wins the clear
    for (genvar p = 0; p < NPORTS; p++) begin : g_trip
        assign trip_set[p] = gang_q ? any_oc : oc_q[p];
        assign trip_ev[p] = trip_set[p] && !trip_reg[p];
        always_ff @(posedge CLK) begin
            if (SYS_RST) begin
                trip_reg[p] <= 1'b0;
            end else if (trip_set[p]) begin
                trip_reg[p] <= 1'b1;
            end else if (wr_clr && HWDATA[p]) begin
                trip_reg[p] <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // port power switching
    // -------------------------------------------------------------
    logic gang_on;
    logic gang_off_ok;

    // ganged supply stays on while any port asks and nothing tripped
    assign gang_on = (|pwr_req_reg) && !(|trip_reg);
    assign gang_off_ok = (pwr_req_reg == 2'h0) || (trip_reg != 2'h0);

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PORT_PWR_EN <= 2'h0;
        end else if (gang_q) begin
            PORT_PWR_EN <= {2{gang_on}};
        end else begin
            PORT_PWR_EN <= pwr_req_reg & ~trip_reg;
        end
    end

    // -------------------------------------------------------------
    // speed gating
    // -------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            UP_SS_EN <= 1'b0;
            UP_HS_EN <= 1'b0;
            DN_SS_EN <= 2'h0;
            DN_HS_EN <= 2'h0;
        end else begin
            UP_SS_EN <= 1'b1;
            UP_HS_EN <= 1'b1;
            DN_SS_EN <= {2{up_ss_q}};
            DN_HS_EN <= {2{up_ss_q || up_hs_q}};
        end
    end

    // -------------------------------------------------------------
    // battery charging mode
    // -------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            CHARGING_DOWNSTREAM_HANDSHAKE <= 1'b0;
            DEDICATED_CHARGE_MODE <= 1'b0;
            AUTO_CHARGE_MODE <= 1'b0;
        end else begin
            CHARGING_DOWNSTREAM_HANDSHAKE <= up_conn_q;
            DEDICATED_CHARGE_MODE <= !up_conn_q && (chg_sel == HPPSC_CHG_DEDICATED);
            AUTO_CHARGE_MODE <= !up_conn_q && (chg_sel == HPPSC_CHG_AUTO);
        end
    end

    // -------------------------------------------------------------
    // interrupt status, clear and enable
    // -------------------------------------------------------------
    logic [2:0] irq_ev;

    assign irq_ev = {up_conn_q != conn_prev_reg, trip_ev};

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            conn_prev_reg <= 1'b0;
            int_stat_reg <= 3'h0;
        end else begin
            conn_prev_reg <= up_conn_q;
            // an event in the clearing cycle survives
            int_stat_reg <= (int_stat_reg & ~(wr_clr ? HWDATA[2:0] : 3'h0)) | irq_ev;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(int_stat_reg & int_en_reg);
        end
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    AST_UP_DUAL: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        !$past(SYS_RST) |-> (UP_SS_EN && UP_HS_EN))
        else $error("upstream speeds not both offered");

    AST_NO_SS: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        !up_ss_q |=> (DN_SS_EN == 2'h0))
        else $error("superspeed offered without upstream superspeed");

    AST_NO_HS: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        (!up_ss_q && !up_hs_q) |=> (DN_HS_EN == 2'h0) && (DN_SS_EN == 2'h0))
        else $error("high speed offered on full-speed upstream");

    AST_INDIV_FOLLOW: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        (!gang_q && !trip_reg[1]) |=> (PORT_PWR_EN[1] == $past(pwr_req_reg[1])))
        else $error("port power does not follow request");

    AST_INDIV_OC: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        (!gang_q && trip_reg[0] && !trip_reg[1] && pwr_req_reg[1])
        |=> (PORT_PWR_EN == 2'h2))
        else $error("overcurrent did not cut only its own port");

    AST_GANG_ON: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        (gang_q && pwr_req_reg != 2'h0 && trip_reg == 2'h0) |=> (PORT_PWR_EN == 2'h3))
        else $error("ganged ports not all powered");

    AST_GANG_OFF: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        ($past(gang_q) && $fell(PORT_PWR_EN[0])) |-> $past(gang_off_ok))
        else $error("ganged supply removed while a port needs power");

    AST_GANG_OC: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        (gang_q && any_oc) |=> (trip_reg == 2'h3) ##1 (PORT_PWR_EN == 2'h0))
        else $error("ganged overcurrent did not cut all ports");

    AST_CHG_HANDSHAKE: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        up_conn_q |=> (CHARGING_DOWNSTREAM_HANDSHAKE && !DEDICATED_CHARGE_MODE))
        else $error("handshake missing while connected");

    AST_DEDICATED: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        (!up_conn_q && chg_sel == HPPSC_CHG_DEDICATED) |=> DEDICATED_CHARGE_MODE)
        else $error("dedicated charging not applied");

    AST_AUTO: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        (!up_conn_q && chg_sel == HPPSC_CHG_AUTO) |=> (AUTO_CHARGE_MODE && !DEDICATED_CHARGE_MODE))
        else $error("auto charging not applied");

    AST_RESET: assert property (
        @(posedge CLK)
        SYS_RST |=> (PORT_PWR_EN == 2'h0) && (int_stat_reg == 3'h0) && !IRQ && !UP_SS_EN)
        else $error("block not idle under reset");

    AST_OC_LATCH: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        $rose(trip_reg[0]) |-> int_stat_reg[0])
        else $error("overcurrent trip not latched in status");
endmodule : hppsc_top

/* verification/hppsc_far_model.sv */
// far-side model: upstream attach pins and downstream overcurrent sensors
`timescale 1ns/100ps
module hppsc_far_model (
    input wire logic clk,
    input wire logic want_ss,
    input wire logic want_hs,
    input wire logic want_conn,
    input wire logic [1:0] want_oc,
    output logic up_ss_link,
    output logic up_hs_link,
    output logic up_connected,
    output logic [1:0] overcur_n
);
    // ---------------------------------------------------------------
    // pin drive
    // ---------------------------------------------------------------
    initial begin
        up_ss_link = 1'b0;
        up_hs_link = 1'b0;
        up_connected = 1'b0;
        overcur_n = 2'h3;
    end

    // pins move only just after an edge of the one shared clock
    always @(posedge clk) begin
        up_ss_link <= want_ss;
        up_hs_link <= want_hs;
        up_connected <= want_conn;
        // sensors pull low on a fault, bit i is port i
        overcur_n <= ~want_oc;
    end
endmodule : hppsc_far_model

/* verification/hppsc_test.sv */
// self-checking bench for the hub port power and speed control block
`timescale 1ns/100ps
module hppsc_test
    import hppsc_pkg::*;
;
    logic clk, sys_rst, hsel, hwrite, ss, hs, conn;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, oc, overcur_n, dn_ss_en, dn_hs_en, port_pwr_en;
    logic [2:0] hsize;
    logic hreadyout, hresp, up_ss_en, up_hs_en, cdh, dcm, acm, irq;
    logic up_ss_link, up_hs_link, up_connected;
    int n_fail, samples_checked, cycles;

    hppsc_top dut_u (.CLK(clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .UP_SS_LINK(up_ss_link), .UP_HS_LINK(up_hs_link), .UP_CONNECTED(up_connected),
        .OVERCUR_N(overcur_n), .UP_SS_EN(up_ss_en), .UP_HS_EN(up_hs_en),
        .DN_SS_EN(dn_ss_en), .DN_HS_EN(dn_hs_en), .PORT_PWR_EN(port_pwr_en),
        .CHARGING_DOWNSTREAM_HANDSHAKE(cdh), .DEDICATED_CHARGE_MODE(dcm),
        .AUTO_CHARGE_MODE(acm), .IRQ(irq));

    hppsc_far_model far_u (.clk(clk), .want_ss(ss), .want_hs(hs), .want_conn(conn),
        .want_oc(oc), .up_ss_link(up_ss_link), .up_hs_link(up_hs_link),
        .up_connected(up_connected), .overcur_n(overcur_n));

    // ---------------------------------------------------------------
    // common tasks
    // ---------------------------------------------------------------
    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task wait_cy(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cy

    // one single word transfer; entered just after a rising edge
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
              output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HPPSC_HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
        check("hresp", 32'(hresp), 32'(HPPSC_HRESP_OKAY));
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        xfer(1'b1, a, d, unused);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] got;
        xfer(1'b0, a, 32'h0, got);
        check(what, got, exp);
    endtask : rd_chk

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task t_reset;
        rd_chk(HPPSC_CTRL_OFS, 32'(HPPSC_CTRL_RST), "ctrl");
        rd_chk(HPPSC_PWRREQ_OFS, 32'(HPPSC_PWRREQ_RST), "pwrreq");
        rd_chk(HPPSC_IEN_OFS, 32'(HPPSC_IEN_RST), "ien");
        rd_chk(8'h18, 32'h0, "unmapped");
        check("pwr", 32'(port_pwr_en), 32'h0);
        check("irq", 32'(irq), 32'h0);
        check("up_en", 32'({up_ss_en, up_hs_en}), 32'h3);
    endtask : t_reset

    task t_speed;
        for (int i = 0; i < 4; i++) begin
            ss <= i[1];
            hs <= i[0];
            conn <= 1'b1;
            wait_cy(5);
            check("dn_ss", 32'(dn_ss_en), 32'({2{i[1]}}));
            check("dn_hs", 32'(dn_hs_en), 32'({2{i[1] | i[0]}}));
            check("up_en", 32'({up_ss_en, up_hs_en}), 32'h3);
        end
    endtask : t_speed

    task t_indiv;
        wr(HPPSC_CTRL_OFS, 32'h0);
        for (int p = 1; p < 4; p++) begin
            wr(HPPSC_PWRREQ_OFS, 32'(p));
            wait_cy(3);
            check("pwr", 32'(port_pwr_en), 32'(p));
        end
        wr(HPPSC_ICLR_OFS, 32'h7);
        wr(HPPSC_IEN_OFS, 32'h3);
        oc <= 2'h1;
        wait_cy(6);
        check("pwr", 32'(port_pwr_en), 32'h2);
        rd_chk(HPPSC_ISTAT_OFS, 32'h1, "istat");
        check("irq", 32'(irq), 32'h1);
        // masking must drop the level even with the status still set
        wr(HPPSC_IEN_OFS, 32'h0);
        wait_cy(2);
        check("irq", 32'(irq), 32'h0);
        wr(HPPSC_IEN_OFS, 32'h3);
        oc <= 2'h0;
        wait_cy(5);
        wr(HPPSC_ICLR_OFS, 32'h1);
        wait_cy(3);
        check("pwr", 32'(port_pwr_en), 32'h3);
        check("irq", 32'(irq), 32'h0);
        rd_chk(HPPSC_ISTAT_OFS, 32'h0, "istat");
    endtask : t_indiv

    task t_gang;
        logic [31:0] st_exp;
        st_exp = 32'(3 << HPPSC_ST_PWR_LSB) | 32'(1 << HPPSC_ST_SS_BIT) | 32'(1 << HPPSC_ST_HS_BIT);
        st_exp = st_exp | 32'(1 << HPPSC_ST_CONN_BIT) | 32'(1 << HPPSC_ST_CHG_LSB);
        wr(HPPSC_CTRL_OFS, 32'h1);
        wr(HPPSC_PWRREQ_OFS, 32'h1);
        wait_cy(3);
        check("pwr", 32'(port_pwr_en), 32'h3);
        wr(HPPSC_PWRREQ_OFS, 32'h2);
        wait_cy(3);
        check("pwr", 32'(port_pwr_en), 32'h3);
        wr(HPPSC_PWRREQ_OFS, 32'h0);
        wait_cy(3);
        check("pwr", 32'(port_pwr_en), 32'h0);
        wr(HPPSC_PWRREQ_OFS, 32'h1);
        oc <= 2'h2;
        wait_cy(6);
        check("pwr", 32'(port_pwr_en), 32'h0);
        check("irq", 32'(irq), 32'h1);
        oc <= 2'h0;
        wait_cy(5);
        wr(HPPSC_ICLR_OFS, 32'h3);
        wait_cy(3);
        check("pwr", 32'(port_pwr_en), 32'h3);
        check("irq", 32'(irq), 32'h0);
        // upstream left at both speeds and connected by the speed scenario
        rd_chk(HPPSC_STATE_OFS, st_exp, "state");
    endtask : t_gang

    task t_charge;
        for (int c = 0; c < 2; c++) begin
            for (int m = 0; m < 3; m++) begin
                conn <= c[0];
                wr(HPPSC_CTRL_OFS, 32'(m << HPPSC_CTRL_CHG_LSB));
                wait_cy(5);
                check("chg", 32'({cdh, dcm, acm}), 32'({c[0], !c[0] && m == 1,
                    !c[0] && m == 2}));
            end
        end
    endtask : t_charge

    task t_midreset;
        wr(HPPSC_CTRL_OFS, 32'h1);
        wr(HPPSC_PWRREQ_OFS, 32'h3);
        wait_cy(3);
        check("pwr", 32'(port_pwr_en), 32'h3);
        sys_rst <= 1'b1;
        wait_cy(2);
        check("pwr", 32'(port_pwr_en), 32'h0);
        sys_rst <= 1'b0;
        wait_cy(1);
        t_reset();
    endtask : t_midreset

    // ---------------------------------------------------------------
    // clock, timeout and main sequence
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // whole run is under two hundred cycles; this ceiling only cuts a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            close_out();
        end
    end

    initial begin
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ss = 1'b0;
        hs = 1'b0;
        conn = 1'b0;
        oc = 2'h0;
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        wait_cy(2);
        sys_rst <= 1'b0;
        wait_cy(1);
        t_reset();
        t_speed();
        t_indiv();
        t_gang();
        t_charge();
        t_midreset();
        close_out();
    end
endmodule : hppsc_test
